// ===== wmi_pkg.sv
// wmi_pkg: operand codes, opcodes, operand limits and step sizes for the
// word move / inverted / indirect execution unit.
// assumes: included before wmi_word_move in compile order.
`default_nettype none

package wmi_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // operand type codes
    localparam logic [2:0] OPT_INPUT    = 3'h0;
    localparam logic [2:0] OPT_OUTPUT   = 3'h1;
    localparam logic [2:0] OPT_RELAY    = 3'h2;
    localparam logic [2:0] OPT_TIMER    = 3'h3;
    localparam logic [2:0] OPT_COUNTER  = 3'h4;
    localparam logic [2:0] OPT_SHIFTREG = 3'h5;
    localparam logic [2:0] OPT_DATAREG  = 3'h6;
    localparam logic [2:0] OPT_CONST    = 3'h7;

    ////////////////////////////////////////////////////////////////////////////
    // instruction codes
    localparam logic [1:0] OP_MOVE_INVERTED          = 2'h0;
    localparam logic [1:0] OP_INDIRECT_MOVE          = 2'h1;
    localparam logic [1:0] OP_INDIRECT_MOVE_INVERTED = 2'h2;
    localparam logic [1:0] OP_MOVE                   = 2'h3;

    ////////////////////////////////////////////////////////////////////////////
    // highest valid operand number per type
    localparam logic [16:0] MAX_INPUT     = 17'h00023; // 35
    localparam logic [16:0] MAX_OUTPUT    = 17'h0001f; // 31
    localparam logic [16:0] MAX_RELAY_SRC = 17'h0013d; // 317
    localparam logic [16:0] MAX_RELAY_DST = 17'h0011f; // 287
    localparam logic [16:0] MAX_TIMCNT    = 17'h0001f; // 31
    localparam logic [16:0] MAX_SHIFTREG  = 17'h0003f; // 63
    localparam logic [16:0] MAX_DATAREG   = 17'h00063; // 99

    ////////////////////////////////////////////////////////////////////////////
    // word geometry
    localparam logic [15:0] PRESET_MAX    = 16'h270f;  // 9999
    localparam int          BIT_STEP_LOG2 = 4;         // 16 points per word
    localparam logic [4:0]  REPEAT_MAX    = 5'h1f;     // 31

endpackage : wmi_pkg

`default_nettype wire

// ===== wmi_word_move.sv
// wmi_word_move: move, move_inverted, indirect_move, indirect_move_inverted on operand memory.
// assumes: memory answers a read in the o_RD_EN cycle and takes a write in the o_WR_EN cycle.
`default_nettype none

module wmi_word_move (
    input  wire logic        I_CORE_CLK,
    input  wire logic        I_SRST,
    input  wire logic        I_CE,
    input  wire logic        i_EXEC,
    input  wire logic        i_COND,
    input  wire logic [1:0]  i_OPCODE,
    input  wire logic [2:0]  i_SRC_TYPE,
    input  wire logic [8:0]  i_SRC_NUM,
    input  wire logic [15:0] i_SRC_CONST,
    input  wire logic        i_SRC_OFF_EN,
    input  wire logic [2:0]  i_SRC_OFF_TYPE,
    input  wire logic [8:0]  i_SRC_OFF_NUM,
    input  wire logic [2:0]  i_DST_TYPE,
    input  wire logic [8:0]  i_DST_NUM,
    input  wire logic        i_DST_OFF_EN,
    input  wire logic [2:0]  i_DST_OFF_TYPE,
    input  wire logic [8:0]  i_DST_OFF_NUM,
    input  wire logic [4:0]  i_REPEAT_COUNT,
    input  wire logic        i_SRC_REP_EN,
    input  wire logic        i_DST_REP_EN,
    input  wire logic        i_ERR_CLEAR,
    input  wire logic [15:0] i_RD_DATA,
    output var  logic        o_RD_EN,
    output var  logic [2:0]  o_RD_TYPE,
    output var  logic [8:0]  o_RD_NUM,
    output var  logic        o_WR_EN,
    output var  logic [2:0]  o_WR_TYPE,
    output var  logic [8:0]  o_WR_NUM,
    output var  logic [15:0] o_WR_DATA,
    output var  logic        o_BUSY,
    output var  logic        o_DONE,
    output var  logic        o_EXEC_ERROR_RELAY,
    output var  logic        o_ERROR_INDICATOR
);
    ////////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic is_bit_type(input logic [2:0] t);
        is_bit_type = (t == wmi_pkg::OPT_INPUT) || (t == wmi_pkg::OPT_OUTPUT) ||
                      (t == wmi_pkg::OPT_RELAY) || (t == wmi_pkg::OPT_SHIFTREG);
    endfunction : is_bit_type

    // number valid for the type; destinations exclude inputs and special relays
    function automatic logic num_ok(input logic [2:0] t, input logic [16:0] n,
                                    input logic dst);
        unique case (t)
            wmi_pkg::OPT_INPUT:    num_ok = !dst && (n <= wmi_pkg::MAX_INPUT);
            wmi_pkg::OPT_OUTPUT:   num_ok = n <= wmi_pkg::MAX_OUTPUT;
            wmi_pkg::OPT_RELAY:    num_ok = n <= (dst ? wmi_pkg::MAX_RELAY_DST
                                                      : wmi_pkg::MAX_RELAY_SRC);
            wmi_pkg::OPT_TIMER,
            wmi_pkg::OPT_COUNTER:  num_ok = n <= wmi_pkg::MAX_TIMCNT;
            wmi_pkg::OPT_SHIFTREG: num_ok = n <= wmi_pkg::MAX_SHIFTREG;
            wmi_pkg::OPT_DATAREG:  num_ok = n <= wmi_pkg::MAX_DATAREG;
            wmi_pkg::OPT_CONST:    num_ok = 1'b0;
        endcase
    endfunction : num_ok

    // repeat displacement: 16 points for bit operands, one word otherwise
    function automatic logic [16:0] rep_step(input logic [2:0] t, input logic [4:0] i,
                                             input logic en);
        logic [16:0] w;
        w = {12'h000, i};
        if (!en)
            rep_step = 17'h00000;
        else if (is_bit_type(t))
            rep_step = w << wmi_pkg::BIT_STEP_LOG2;
        else
            rep_step = w;
    endfunction : rep_step

    ////////////////////////////////////////////////////////////////////////////
    // state
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SOFF,
        ST_DOFF,
        ST_ADDR,
        ST_SRC
    } wmi_state_t;

    wmi_state_t  state_reg;
    logic [1:0]  op_reg;
    logic [2:0]  src_type_reg;
    logic [8:0]  src_num_reg;
    logic [15:0] const_reg;
    logic [2:0]  dst_type_reg;
    logic [8:0]  dst_num_reg;
    logic        doff_en_reg;
    logic [2:0]  doff_type_reg;
    logic [8:0]  doff_num_reg;
    logic [15:0] soff_val_reg;
    logic [15:0] doff_val_reg;
    logic [4:0]  cycles_reg;
    logic [4:0]  iter_reg;
    logic        src_rep_reg;
    logic        dst_rep_reg;

    ////////////////////////////////////////////////////////////////////////////
    // decode
    wire logic        start_ok   = I_CE && i_EXEC && i_COND && (state_reg == ST_IDLE);
    wire logic        start_ind  = (i_OPCODE == wmi_pkg::OP_INDIRECT_MOVE) ||
                                   (i_OPCODE == wmi_pkg::OP_INDIRECT_MOVE_INVERTED);
    wire logic        indirect   = (op_reg == wmi_pkg::OP_INDIRECT_MOVE) ||
                                   (op_reg == wmi_pkg::OP_INDIRECT_MOVE_INVERTED);
    wire logic        invert     = (op_reg == wmi_pkg::OP_MOVE_INVERTED) ||
                                   (op_reg == wmi_pkg::OP_INDIRECT_MOVE_INVERTED);
    wire logic [4:0]  cycles_in  = ((i_SRC_REP_EN || i_DST_REP_EN) && (i_REPEAT_COUNT != 5'h00))
                                   ? i_REPEAT_COUNT : 5'h01;
    wire logic        last_cycle = (iter_reg + 5'h01) >= cycles_reg;
    // resolved numbers: base plus offset (zero when omitted) plus repeat step
    wire logic [16:0] src_res = {8'h00, src_num_reg} + {1'b0, soff_val_reg} +
                                rep_step(src_type_reg, iter_reg, src_rep_reg);
    wire logic [16:0] dst_res = {8'h00, dst_num_reg} + {1'b0, doff_val_reg} +
                                rep_step(dst_type_reg, iter_reg, dst_rep_reg);
    // base type fixes the operand class; constant source only for direct move
    wire logic        src_is_const = (src_type_reg == wmi_pkg::OPT_CONST);
    wire logic        range_err    = indirect &&
                                     (!num_ok(src_type_reg, src_res, 1'b0) ||
                                      !num_ok(dst_type_reg, dst_res, 1'b1));
    // word to store: bit packing arrives with lowest point in bit 0
    wire logic [15:0] src_word = src_is_const ? const_reg : i_RD_DATA;
    wire logic [15:0] inv_word = invert ? ~src_word : src_word;
    wire logic        dst_tc   = (dst_type_reg == wmi_pkg::OPT_TIMER) ||
                                 (dst_type_reg == wmi_pkg::OPT_COUNTER);
    wire logic [15:0] out_word = (dst_tc && (inv_word > wmi_pkg::PRESET_MAX))
                                 ? wmi_pkg::PRESET_MAX : inv_word;
    wire logic        do_write = (state_reg == ST_SRC) ||
                                 ((state_reg == ST_ADDR) && src_is_const && !range_err);
    wire logic        err_set  = (state_reg == ST_ADDR) && range_err;

    ////////////////////////////////////////////////////////////////////////////
    // sequencer
    always_ff @(posedge I_CORE_CLK)
    begin
        if (I_SRST)
        begin
            // operand latches load on every start; only control state is reset
            state_reg     <= ST_IDLE;
            o_RD_EN       <= 1'b0;
            o_RD_TYPE     <= wmi_pkg::OPT_DATAREG;
            o_RD_NUM      <= 9'h000;
            o_WR_EN       <= 1'b0;
            o_WR_TYPE     <= wmi_pkg::OPT_DATAREG;
            o_WR_NUM      <= 9'h000;
            o_WR_DATA     <= 16'h0000;
            o_BUSY        <= 1'b0;
            o_DONE        <= 1'b0;
        end
        else if (I_CE)
        begin
            o_RD_EN <= 1'b0;
            o_WR_EN <= 1'b0;
            o_DONE  <= 1'b0;
            unique case (state_reg)
                ST_IDLE:
                begin
                    // condition off: nothing is latched or written
                    if (start_ok)
                    begin
                        op_reg        <= i_OPCODE;
                        src_type_reg  <= i_SRC_TYPE;
                        src_num_reg   <= i_SRC_NUM;
                        const_reg     <= i_SRC_CONST;
                        dst_type_reg  <= i_DST_TYPE;
                        dst_num_reg   <= i_DST_NUM;
                        doff_en_reg   <= start_ind && i_DST_OFF_EN;
                        doff_type_reg <= i_DST_OFF_TYPE;
                        doff_num_reg  <= i_DST_OFF_NUM;
                        soff_val_reg  <= 16'h0000;
                        doff_val_reg  <= 16'h0000;
                        cycles_reg    <= cycles_in;
                        src_rep_reg   <= i_SRC_REP_EN;
                        dst_rep_reg   <= i_DST_REP_EN;
                        iter_reg      <= 5'h00;
                        o_BUSY        <= 1'b1;
                        // offsets themselves never repeat and read current values
                        if (start_ind && i_SRC_OFF_EN)
                        begin
                            o_RD_EN   <= 1'b1;
                            o_RD_TYPE <= i_SRC_OFF_TYPE;
                            o_RD_NUM  <= i_SRC_OFF_NUM;
                            state_reg <= ST_SOFF;
                        end
                        else if (start_ind && i_DST_OFF_EN)
                        begin
                            o_RD_EN   <= 1'b1;
                            o_RD_TYPE <= i_DST_OFF_TYPE;
                            o_RD_NUM  <= i_DST_OFF_NUM;
                            state_reg <= ST_DOFF;
                        end
                        else
                            state_reg <= ST_ADDR;
                    end
                end
                ST_SOFF:
                begin
                    soff_val_reg <= i_RD_DATA;
                    if (doff_en_reg)
                    begin
                        o_RD_EN   <= 1'b1;
                        o_RD_TYPE <= doff_type_reg;
                        o_RD_NUM  <= doff_num_reg;
                        state_reg <= ST_DOFF;
                    end
                    else
                        state_reg <= ST_ADDR;
                end
                ST_DOFF:
                begin
                    doff_val_reg <= i_RD_DATA;
                    state_reg    <= ST_ADDR;
                end
                ST_ADDR:
                begin
                    if (range_err)
                    begin
                        o_BUSY    <= 1'b0;
                        o_DONE    <= 1'b1;
                        state_reg <= ST_IDLE;
                    end
                    else if (!src_is_const)
                    begin
                        // timer/counter sources read as current value
                        o_RD_EN   <= 1'b1;
                        o_RD_TYPE <= src_type_reg;
                        o_RD_NUM  <= src_res[8:0];
                        state_reg <= ST_SRC;
                    end
                end
                ST_SRC:
                begin
                end
            endcase
            if (do_write)
            begin
                o_WR_EN   <= 1'b1;
                o_WR_TYPE <= dst_type_reg;
                o_WR_NUM  <= dst_res[8:0];
                o_WR_DATA <= out_word;
                iter_reg  <= iter_reg + 5'h01;
                if (last_cycle)
                begin
                    o_BUSY    <= 1'b0;
                    o_DONE    <= 1'b1;
                    state_reg <= ST_IDLE;
                end
                else
                    state_reg <= ST_ADDR;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sticky error flags; a new error wins over a clear in the same cycle

    always_ff @(posedge I_CORE_CLK)
    begin
        if (I_SRST)
        begin
            o_EXEC_ERROR_RELAY <= 1'b0;
            o_ERROR_INDICATOR  <= 1'b0;
        end
        else if (I_CE)
        begin
            if (err_set)
            begin
                o_EXEC_ERROR_RELAY <= 1'b1;
                o_ERROR_INDICATOR  <= 1'b1;
            end
            else if (i_ERR_CLEAR)
            begin
                o_EXEC_ERROR_RELAY <= 1'b0;
                o_ERROR_INDICATOR  <= 1'b0;
            end
        end
    end

endmodule : wmi_word_move

`default_nettype wire

// ===== wmi_word_move_props.sv
// wmi_chk: port-level checks on the word move unit.
// assumes: bound to wmi_word_move by the testbench; I_CE held high.
`default_nettype none
module wmi_chk (
    input wire logic        I_CORE_CLK,
    input wire logic        I_SRST,
    input wire logic        i_EXEC,
    input wire logic        i_COND,
    input wire logic [1:0]  i_OPCODE,
    input wire logic        i_ERR_CLEAR,
    input wire logic        o_RD_EN,
    input wire logic        o_WR_EN,
    input wire logic [2:0]  o_WR_TYPE,
    input wire logic [15:0] o_WR_DATA,
    input wire logic        o_BUSY,
    input wire logic        o_DONE,
    input wire logic        o_EXEC_ERROR_RELAY,
    input wire logic        o_ERROR_INDICATOR
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking dc @(posedge I_CORE_CLK);
    endclocking
    default disable iff (I_SRST);
    wire logic go = i_EXEC && i_COND && !o_BUSY;
    wire logic tc = o_WR_TYPE == wmi_pkg::OPT_TIMER || o_WR_TYPE == wmi_pkg::OPT_COUNTER;
    ////////////////////////////////////////
    sequence s_go;
        go;
    endsequence
    sequence s_go_direct;
        s_go ##0 (i_OPCODE == wmi_pkg::OP_MOVE_INVERTED);
    endsequence
    property p_start; s_go_direct |=> o_BUSY && !o_WR_EN; endproperty
    property p_off; i_EXEC && !i_COND && !o_BUSY |=> !o_BUSY && !o_WR_EN; endproperty
    property p_run; s_go |-> ##[1:80] o_DONE; endproperty
    property p_clamp; o_WR_EN && tc |-> o_WR_DATA <= wmi_pkg::PRESET_MAX; endproperty
    property p_dst; o_WR_EN |-> !(o_WR_TYPE inside {3'h0, 3'h7}); endproperty
    property p_same; o_EXEC_ERROR_RELAY == o_ERROR_INDICATOR; endproperty
    property p_rise; $rose(o_EXEC_ERROR_RELAY) |-> o_DONE; endproperty
    property p_hold; !o_BUSY && !i_COND && !i_ERR_CLEAR |=> $stable(o_EXEC_ERROR_RELAY); endproperty
    property p_clr; i_ERR_CLEAR && !o_BUSY |=> !o_EXEC_ERROR_RELAY; endproperty
    property p_rd; o_RD_EN |-> o_BUSY; endproperty
    a_start: assert property (p_start) else $error("start not taken");
    a_off: assert property (p_off) else $error("ran with condition off");
    a_run: assert property (p_run) else $error("run did not finish");
    a_clamp: assert property (p_clamp) else $error("preset above limit");
    a_dst: assert property (p_dst) else $error("write to input or constant");
    a_same: assert property (p_same) else $error("error outputs differ");
    a_rise: assert property (p_rise) else $error("error set outside done");
    a_hold: assert property (p_hold) else $error("error flag changed idle");
    a_clr: assert property (p_clr) else $error("error flag not cleared");
    a_rd: assert property (p_rd) else $error("read while idle");
endmodule : wmi_chk
`default_nettype wire

// ===== wmi_mem_model.sv
// wmi_mem_model: behavioural operand memory behind the move unit.
// assumes: reads answered in the request cycle, writes taken on their edge.
`default_nettype none
module wmi_mem_model (
    input  wire logic        i_clk,
    input  wire logic        i_re,
    input  wire logic [2:0]  i_rt,
    input  wire logic [8:0]  i_rn,
    input  wire logic        i_we,
    input  wire logic [2:0]  i_wt,
    input  wire logic [8:0]  i_wn,
    input  wire logic [15:0] i_wd,
    output var  logic [15:0] o_rd
);
    timeunit 1ns;
    timeprecision 1ns;
    logic        pts [8][1024];
    logic [15:0] cur [8][512];
    logic [15:0] last;
    logic [15:0] word;
    int          wr_cnt = 0;
    wire  logic  rbit = i_rt <= wmi_pkg::OPT_RELAY || i_rt == wmi_pkg::OPT_SHIFTREG;
    wire  logic  wbit = i_wt <= wmi_pkg::OPT_RELAY || i_wt == wmi_pkg::OPT_SHIFTREG;
    // idle bus shows the inverse of the last word
    always_comb
    begin
        word = cur[i_rt][i_rn];
        for (int i = 0; i < 16; i++)
            if (rbit)
                word[i] = pts[i_rt][int'(i_rn) + i];
        o_rd = i_re ? word : ~last;
    end
    always @(posedge i_clk)
    begin
        if (i_re)
            last <= word;
        if (i_we)
            wr_cnt <= wr_cnt + 1;
        for (int i = 0; i < 16; i++)
            if (i_we && wbit)
                pts[i_wt][int'(i_wn) + i] <= i_wd[i];
        if (i_we && !wbit)
            cur[i_wt][i_wn] <= i_wd;
    end
endmodule : wmi_mem_model
`default_nettype wire

// ===== testbench.sv
// testbench: directed scenarios for wmi_word_move with an operand memory model.
// assumes: wmi_pkg, wmi_word_move, wmi_chk and wmi_mem_model compiled first.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0, srst = 1'b1, exec = 1'b0, cond = 1'b0, clr = 1'b0;
    logic        soe = 1'b0, doe = 1'b0, srep = 1'b0, drep = 1'b0;
    logic        rd_en, wr_en, busy, done, err, ind;
    logic [1:0]  opc = 2'h0;
    logic [2:0]  st = 3'h0, sot = 3'h6, dt = 3'h6, dot = 3'h6, rt, wt;
    logic [4:0]  repeat_count = 5'h01;
    logic [8:0]  sn = 9'h000, son = 9'h000, dn = 9'h000, don = 9'h000, rn, wn;
    logic [15:0] scon = 16'h0000, rdat, wdat;
    int          mismatches = 0, total_checks = 0, w0 = 0;
    always #5 clk = ~clk;
    wmi_word_move dut (
        .I_CORE_CLK(clk), .I_SRST(srst), .I_CE(1'b1), .i_EXEC(exec), .i_COND(cond),
        .i_OPCODE(opc), .i_SRC_TYPE(st), .i_SRC_NUM(sn), .i_SRC_CONST(scon),
        .i_SRC_OFF_EN(soe), .i_SRC_OFF_TYPE(sot), .i_SRC_OFF_NUM(son), .i_DST_TYPE(dt),
        .i_DST_NUM(dn), .i_DST_OFF_EN(doe), .i_DST_OFF_TYPE(dot), .i_DST_OFF_NUM(don),
        .i_REPEAT_COUNT(repeat_count), .i_SRC_REP_EN(srep), .i_DST_REP_EN(drep), .i_ERR_CLEAR(clr),
        .i_RD_DATA(rdat), .o_RD_EN(rd_en), .o_RD_TYPE(rt), .o_RD_NUM(rn), .o_WR_EN(wr_en),
        .o_WR_TYPE(wt), .o_WR_NUM(wn), .o_WR_DATA(wdat), .o_BUSY(busy), .o_DONE(done),
        .o_EXEC_ERROR_RELAY(err), .o_ERROR_INDICATOR(ind));
    wmi_mem_model mem (
        .i_clk(clk), .i_re(rd_en), .i_rt(rt), .i_rn(rn), .i_we(wr_en), .i_wt(wt),
        .i_wn(wn), .i_wd(wdat), .o_rd(rdat));
    ////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [15:0] pw(input int n);
        logic [15:0] w;
        for (int i = 0; i < 16; i++)
            w[i] = mem.pts[2][n + i];
        return w;
    endfunction : pw
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_sim
    // one execute strobe, then a bounded wait for done
    task automatic run(input logic c);
        w0 = mem.wr_cnt;
        @(posedge clk);
        #1 exec = 1'b1;
        cond = c;
        @(posedge clk);
        #1 exec = 1'b0;
        for (int i = 0; i < 100 && done !== 1'b1; i++)
            @(posedge clk) #1;
        if (c && done !== 1'b1)
        begin
            chk(16'h0000, 16'h0001);
            end_sim();
        end
        // the last write leaves with done and lands in memory one edge later
        @(posedge clk) #1;
    endtask : run
    task automatic mv(input logic [1:0] o, input logic [2:0] a, input logic [8:0] b,
                      input logic [2:0] c, input logic [8:0] d);
        {opc, st, sn, dt, dn} = {o, a, b, c, d};
        {soe, doe, srep, drep, repeat_count} = {4'h0, 5'h01};
    endtask : mv
    ////////////////////////////////////////
    task automatic t_const;
        mv(2'h0, 3'h7, 9'd0, 3'h6, 9'd2);
        scon = 16'd810;
        run(1'b1);
        chk(mem.cur[6][2], 16'hfcd5);
    endtask : t_const
    task automatic t_bits;
        for (int i = 0; i < 16; i++)
            mem.pts[2][10 + i] = 1'(16'ha5c3 >> i);
        mv(2'h0, 3'h2, 9'd10, 3'h2, 9'd50);
        run(1'b1);
        chk(pw(50), 16'h5a3c);
    endtask : t_bits
    task automatic t_rep;
        for (int i = 0; i < 3; i++)
            mem.cur[6][10 + i] = 16'(16'h1111 * (i + 1));
        mv(2'h0, 3'h6, 9'd10, 3'h2, 9'd100);
        {repeat_count, srep, drep} = {5'h03, 2'b11};
        run(1'b1);
        for (int i = 0; i < 3; i++)
            chk(pw(100 + 16 * i), ~16'(16'h1111 * (i + 1)));
    endtask : t_rep
    task automatic t_preset;
        mem.cur[3][4] = 16'h0000;
        mv(2'h0, 3'h3, 9'd4, 3'h4, 9'd5);
        run(1'b1);
        chk(mem.cur[4][5], 16'h270f);
    endtask : t_preset
    task automatic t_indirect_move;
        mv(2'h1, 3'h6, 9'd20, 3'h6, 9'd10);
        {soe, sot, son, doe, dot, don} = {1'b1, 3'h4, 9'd10, 1'b1, 3'h6, 9'd25};
        {mem.cur[4][10], mem.cur[6][25], mem.cur[6][24]} = {16'd4, 16'd20, 16'hbeef};
        run(1'b1);
        chk(mem.cur[6][30], 16'hbeef);
    endtask : t_indirect_move
    task automatic t_indirect_move_inverted;
        mv(2'h2, 3'h4, 9'd10, 3'h6, 9'd30);
        {soe, sot, son, doe, dot, don} = {1'b1, 3'h6, 9'd10, 1'b1, 3'h6, 9'd20};
        {mem.cur[6][10], mem.cur[6][20], mem.cur[4][14]} = {16'd4, 16'd15, 16'h1234};
        run(1'b1);
        chk(mem.cur[6][45], 16'hedcb);
    endtask : t_indirect_move_inverted
    task automatic t_noff;
        mv(2'h1, 3'h6, 9'd5, 3'h6, 9'd6);
        {son, don, mem.cur[6][3], mem.cur[6][5]} = {9'd3, 9'd3, 16'd2, 16'h77aa};
        run(1'b1);
        chk(mem.cur[6][6], 16'h77aa);
    endtask : t_noff
    // out-of-range destination, constant base, relay destination past 287
    task automatic t_err;
        logic [8:0] dns [3] = '{9'd90, 9'd1, 9'd280};
        for (int i = 0; i < 3; i++)
        begin
            mv(2'h1, i == 1 ? 3'h7 : 3'h6, 9'd1, i == 2 ? 3'h2 : 3'h6, dns[i]);
            {doe, don, mem.cur[6][3]} = {1'b1, 9'd3, i == 2 ? 16'd10 : 16'd20};
            run(1'b1);
            chk({15'h0, err}, 16'h0001);
            chk(16'(mem.wr_cnt - w0), 16'h0000);
            if (i < 2)
            begin
                clr = 1'b1;
                @(posedge clk) #1 clr = 1'b0;
            end
        end
        // a legal move with condition off: no write, sticky error left standing
        mv(2'h0, 3'h7, 9'd0, 3'h6, 9'd2);
        run(1'b0);
        chk({15'h0, err}, 16'h0001);
        chk(16'(mem.wr_cnt - w0), 16'h0000);
        clr = 1'b1;
        @(posedge clk) #1 clr = 1'b0;
        chk({14'h0, err, ind}, 16'h0000);
    endtask : t_err
    initial
    begin
        repeat (12) @(posedge clk);
        #1 srst = 1'b0;
        t_const();
        t_bits();
        t_rep();
        t_preset();
        t_indirect_move();
        t_indirect_move_inverted();
        t_noff();
        t_err();
        end_sim();
    end
endmodule : testbench
bind wmi_word_move wmi_chk chk_i (.I_CORE_CLK, .I_SRST, .i_EXEC, .i_COND, .i_OPCODE,
    .i_ERR_CLEAR, .o_RD_EN, .o_WR_EN, .o_WR_TYPE, .o_WR_DATA, .o_BUSY, .o_DONE,
    .o_EXEC_ERROR_RELAY, .o_ERROR_INDICATOR);
`default_nettype wire
